// ==== bal_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bal_defs.svh"
// Byte arithmetic and logic datapath with its own accumulator, flags and pointer pair.
// One clock is one processor state; the state counts of each form are kept unless a memory fetch runs late.
module bal_top (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                start,
  input  wire logic [4:0]          op,
  input  wire logic [1:0]          src,
  input  wire logic [7:0]          reg_operand,
  input  wire logic [7:0]          imm_byte,
  input  wire logic [15:0]         pair_operand,
  input  wire logic [7:0]          mem_rdata,
  input  wire logic                mem_rvalid,
  input  wire logic                acc_load,
  input  wire logic [7:0]          acc_load_val,
  input  wire logic                ptr_load,
  input  wire logic [15:0]         ptr_load_val,
  output logic [7:0]               acc,
  output bal_pkg::bal_flags_t      flags,
  output logic [15:0]              pointer_pair,
  output logic [15:0]              pair_result,
  output logic [7:0]               reg_result,
  output logic                     reg_wr,
  output logic                     pair_wr,
  output logic                     mem_rd,
  output logic                     mem_wr,
  output logic [15:0]              mem_addr,
  output logic [7:0]               mem_wdata,
  output logic                     done,
  output logic                     busy
);
  import bal_pkg::*;

  // =====================================================================
  // Held instruction and state.
  bal_state_t  st_q,  st_d;   // Sequencer phase.
  logic [4:0]  op_q;          // Operation being run.
  logic [1:0]  src_q;         // Operand source being used.
  logic [7:0]  opnd_q;        // Captured second operand.
  logic [7:0]  acc_q;         // Accumulator.
  bal_flags_t  flg_q;         // Condition flags.
  logic [15:0] ptr_q;         // Pointer pair.
  logic [15:0] pres_q;        // Pair result.
  logic [7:0]  rres_q;        // Register result.
  logic        reg_wr_q;      // Register write strobe.
  logic        pair_wr_q;     // Pair write strobe.
  logic        mem_rd_q;      // Memory read request.
  logic        mem_wr_q;      // Memory write strobe.
  logic [7:0]  mwd_q;         // Memory write data.
  logic        done_q;        // Completion pulse.
  logic        busy_q;        // Instruction in flight.

  // =====================================================================
  // Decode.
  wire         is_mem   = (src == `BAL_SRC_MEM);
  wire         is_imm   = (src == `BAL_SRC_IMM);
  wire         is_incdec = (op == `BAL_OP_INC) || (op == `BAL_OP_DEC);
  wire         is_pair  = (op == `BAL_OP_DECP) || (op == `BAL_OP_PADD);
  wire         q_incdec = (op_q == `BAL_OP_INC) || (op_q == `BAL_OP_DEC);
  wire         q_cmp    = (op_q == `BAL_OP_CMP);
  wire [7:0]   sel_opnd = is_imm ? imm_byte : reg_operand;
  // State count: memory read-modify-write and pair add take 10.
  wire [3:0]   n_states =
    (op == `BAL_OP_PADD) ? `BAL_ST_10 :
    (is_incdec && is_mem) ? `BAL_ST_10 :
    (is_incdec || op == `BAL_OP_DECP) ? `BAL_ST_5 :
    (is_mem || is_imm) ? `BAL_ST_7 :
    `BAL_ST_4;
  wire [16:0]  psum  = {1'b0, ptr_q} + {1'b0, pair_operand};
  wire [15:0]  pdec  = pair_operand - 16'h0001;

  // =====================================================================
  // Arithmetic core and state timer.
  bal_res_if   rif ();
  assign rif.a_in = acc_q;
  assign rif.b_in = opnd_q;
  assign rif.op   = op_q;
  assign rif.f_in = flg_q;
  bal_core u_core (
    .r (rif)
  );
  wire         t_last;
  wire         t_busy;
  wire         go = start && (st_q == BAL_IDLE);
  bal_timer u_timer (
    .clk    (clk),
    .nrst   (nrst),
    .load   (go),
    .states (n_states),
    .last   (t_last),
    .busy   (t_busy)
  );

  // =====================================================================
  // Sequencer: fetch memory operand, wait out states, then retire.
  always_comb begin
    st_d = st_q;
    case (st_q)
      BAL_IDLE: begin
        if (go) begin
          st_d = (is_mem && !is_pair) ? BAL_FETCH : BAL_RUN;
        end
      end
      BAL_FETCH: begin
        if (mem_rvalid) begin
          st_d = BAL_RUN;
        end
      end
      BAL_RUN: begin
        // Retire on the last state, or at once if the fetch ran late.
        if (t_last || !t_busy) begin
          st_d = BAL_WRITE;
        end
      end
      default: begin
        st_d = BAL_IDLE;
      end
    endcase
  end

  // =====================================================================
  // State register and capture of the instruction.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= BAL_IDLE;
      op_q   <= 5'h00;
      src_q  <= `BAL_SRC_REG;
      opnd_q <= `BAL_RST_BYTE;
    end else begin
      st_q <= st_d;
      if (go) begin
        op_q   <= op;
        src_q  <= src;
        opnd_q <= sel_opnd;
      end else if (st_q == BAL_FETCH && mem_rvalid) begin
        opnd_q <= mem_rdata;
      end
    end
  end

  // =====================================================================
  // Accumulator, flags and pointer pair update on retire.
  wire retire = (st_q == BAL_WRITE);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= `BAL_RST_BYTE;
      flg_q <= '0;
      ptr_q <= `BAL_RST_WORD;
    end else if (retire) begin
      if (op_q == `BAL_OP_PADD) begin
        ptr_q <= psum[15:0];
        flg_q.carry_bit <= psum[16];
      end else if (op_q != `BAL_OP_DECP) begin
        flg_q <= rif.f_out;
        if (!q_cmp && !q_incdec) begin
          acc_q <= rif.res;
        end
      end
    end else begin
      if (acc_load) begin
        acc_q <= acc_load_val;
      end
      if (ptr_load) begin
        ptr_q <= ptr_load_val;
      end
    end
  end

  // =====================================================================
  // Result strobes for register, pair and memory targets.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pres_q    <= `BAL_RST_WORD;
      rres_q    <= `BAL_RST_BYTE;
      reg_wr_q  <= 1'b0;
      pair_wr_q <= 1'b0;
      mem_wr_q  <= 1'b0;
      mwd_q     <= `BAL_RST_BYTE;
      done_q    <= 1'b0;
    end else begin
      reg_wr_q  <= retire && q_incdec && (src_q != `BAL_SRC_MEM);
      mem_wr_q  <= retire && q_incdec && (src_q == `BAL_SRC_MEM);
      pair_wr_q <= retire && (op_q == `BAL_OP_DECP);
      done_q    <= retire;
      if (retire) begin
        rres_q <= rif.res;
        mwd_q  <= rif.res;
        pres_q <= (op_q == `BAL_OP_PADD) ? psum[15:0] : pdec;
      end
    end
  end

  // Memory read request stands while the operand is awaited.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_rd_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      mem_rd_q <= (st_d == BAL_FETCH);
      busy_q   <= (st_d != BAL_IDLE);
    end
  end

  assign acc          = acc_q;
  assign flags        = flg_q;
  assign pointer_pair = ptr_q;
  assign pair_result  = pres_q;
  assign reg_result   = rres_q;
  assign reg_wr       = reg_wr_q;
  assign pair_wr      = pair_wr_q;
  assign mem_rd       = mem_rd_q;
  assign mem_wr       = mem_wr_q;
  assign mem_addr     = ptr_q;
  assign mem_wdata    = mwd_q;
  assign done         = done_q;
  assign busy         = busy_q;
endmodule
`default_nettype wire

// ==== bal_defs.svh ====
`ifndef BAL_DEFS_SVH
`define BAL_DEFS_SVH

// =====================================================================
// Operation codes on the op port.
`define BAL_OP_SUB      5'h00
`define BAL_OP_SBB      5'h01
`define BAL_OP_INC      5'h02
`define BAL_OP_DEC      5'h03
`define BAL_OP_DECP     5'h04
`define BAL_OP_PADD     5'h05
`define BAL_OP_FIX      5'h06
`define BAL_OP_AND      5'h07
`define BAL_OP_XOR      5'h08
`define BAL_OP_OR       5'h09
`define BAL_OP_CMP      5'h0a
`define BAL_OP_RLC      5'h0b
`define BAL_OP_RRC      5'h0c
`define BAL_OP_RAL      5'h0d
// Operand source codes on the src port.
`define BAL_SRC_REG     2'h0
`define BAL_SRC_MEM     2'h1
`define BAL_SRC_IMM     2'h2
// State counts per instruction form.
`define BAL_ST_4        4'h4
`define BAL_ST_5        4'h5
`define BAL_ST_7        4'h7
`define BAL_ST_10       4'ha
// Decimal fixup constants.
`define BAL_NIB_LIMIT   4'h9
`define BAL_FIX_ADD     4'h6
// Reset values.
`define BAL_RST_BYTE    8'h00
`define BAL_RST_WORD    16'h0000
`endif

// ==== bal_pkg.sv ====
package bal_pkg;
  // Sequencer phases of one instruction.
  typedef enum logic [1:0] {
    BAL_IDLE,
    BAL_FETCH,
    BAL_RUN,
    BAL_WRITE
  } bal_state_t;
  // Five condition flags.
  typedef struct packed {
    logic sign;
    logic zero;
    logic nibble_carry_bit;
    logic parity;
    logic carry_bit;
  } bal_flags_t;
endpackage

// ==== bal_res_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Result bundle between the arithmetic core and the sequencer.
interface bal_res_if;
  logic [7:0]         a_in;     // Accumulator operand.
  logic [7:0]         b_in;     // Second operand.
  logic [4:0]         op;       // Operation code.
  bal_pkg::bal_flags_t f_in;    // Flags before the operation.
  logic [7:0]         res;      // Eight-bit result.
  bal_pkg::bal_flags_t f_out;   // Flags after the operation.
  modport core (input a_in, input b_in, input op, input f_in, output res, output f_out);
  modport user (output a_in, output b_in, output op, output f_in, input res, input f_out);
endinterface
`default_nettype wire

// ==== bal_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bal_defs.svh"
// Combinational byte arithmetic and flag logic.
module bal_core (
  bal_res_if.core r
);
  import bal_pkg::*;
  // =====================================================================
  // Arithmetic terms.
  logic [8:0] diff;      // Difference with borrow out in bit 8.
  logic [4:0] ldiff;     // Low nibble difference for the nibble borrow.
  logic       bin;       // Borrow in.
  logic [8:0] inc9;      // Increment result.
  logic [4:0] linc;      // Low nibble increment.
  logic [4:0] ldec;      // Low nibble decrement.
  logic       lo_fix;    // Low nibble needs adjustment.
  logic [7:0] fix1;      // After the first fixup step.
  logic       hi_fix;    // High nibble needs adjustment.
  logic [8:0] fix2;      // After the second fixup step.
  logic [4:0] lfix;      // Low nibble sum of the first step.
  assign bin    = (r.op == `BAL_OP_SBB) ? r.f_in.carry_bit : 1'b0;
  assign diff   = {1'b0, r.a_in} - {1'b0, r.b_in} - {8'h00, bin};
  assign ldiff  = {1'b0, r.a_in[3:0]} - {1'b0, r.b_in[3:0]} - {4'h0, bin};
  assign inc9   = {1'b0, r.b_in} + 9'h001;
  assign linc   = {1'b0, r.b_in[3:0]} + 5'h01;
  assign ldec   = {1'b0, r.b_in[3:0]} - 5'h01;
  assign lo_fix = (r.a_in[3:0] > `BAL_NIB_LIMIT) || r.f_in.nibble_carry_bit;
  assign lfix   = {1'b0, r.a_in[3:0]} + (lo_fix ? {1'b0, `BAL_FIX_ADD} : 5'h00);
  assign fix1   = r.a_in + (lo_fix ? {4'h0, `BAL_FIX_ADD} : 8'h00);
  assign hi_fix = (fix1[7:4] > `BAL_NIB_LIMIT) || r.f_in.carry_bit;
  assign fix2   = {1'b0, fix1} + (hi_fix ? {1'b0, `BAL_FIX_ADD, 4'h0} : 9'h000);

  // =====================================================================
  // Result and flag selection per operation.
  always_comb begin
    r.res   = r.a_in;
    r.f_out = r.f_in;
    case (r.op)
      `BAL_OP_SUB, `BAL_OP_SBB, `BAL_OP_CMP: begin
        // Compare produces the same flags; the sequencer skips the write.
        r.res = diff[7:0];
        r.f_out.carry_bit = diff[8];
        r.f_out.nibble_carry_bit = ldiff[4];
      end
      `BAL_OP_INC: begin
        r.res = inc9[7:0];
        r.f_out.nibble_carry_bit = linc[4];
      end
      `BAL_OP_DEC: begin
        r.res = r.b_in - 8'h01;
        r.f_out.nibble_carry_bit = ldec[4];
      end
      `BAL_OP_FIX: begin
        r.res = fix2[7:0];
        r.f_out.carry_bit = fix2[8] | r.f_in.carry_bit;
        r.f_out.nibble_carry_bit = lfix[4];
      end
      `BAL_OP_AND: begin
        r.res = r.a_in & r.b_in;
        r.f_out.carry_bit = 1'b0;
        r.f_out.nibble_carry_bit = 1'b0;
      end
      `BAL_OP_XOR: begin
        r.res = r.a_in ^ r.b_in;
        r.f_out.carry_bit = 1'b0;
        r.f_out.nibble_carry_bit = 1'b0;
      end
      `BAL_OP_OR: begin
        r.res = r.a_in | r.b_in;
        r.f_out.carry_bit = 1'b0;
        r.f_out.nibble_carry_bit = 1'b0;
      end
      `BAL_OP_RLC: begin
        r.res = {r.a_in[6:0], r.a_in[7]};
        r.f_out.carry_bit = r.a_in[7];
      end
      `BAL_OP_RRC: begin
        r.res = {r.a_in[0], r.a_in[7:1]};
        r.f_out.carry_bit = r.a_in[0];
      end
      `BAL_OP_RAL: begin
        r.res = {r.a_in[6:0], r.f_in.carry_bit};
        r.f_out.carry_bit = r.a_in[7];
      end
      default: begin
        r.res = r.a_in;
      end
    endcase
    // Rotates, pair decrement and pair add leave zero, sign and parity alone; all others set them.
    if (r.op != `BAL_OP_RLC && r.op != `BAL_OP_RRC && r.op != `BAL_OP_RAL &&
        r.op != `BAL_OP_DECP && r.op != `BAL_OP_PADD) begin
      r.f_out.zero   = (r.res == 8'h00);
      r.f_out.sign   = r.res[7];
      r.f_out.parity = ~(^r.res);
    end
  end
endmodule
`default_nettype wire

// ==== bal_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bal_defs.svh"
// Counts the states of one instruction; flags the last one.
module bal_timer (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [3:0] states,
  output logic            last,
  output logic            busy
);
  import bal_pkg::*;
  logic [3:0] cnt_q;   // States still to run.
  // =====================================================================
  // Down counter; loading restarts it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
    end else if (load) begin
      cnt_q <= states - 4'h1;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign busy = (cnt_q != 4'h0);
  assign last = (cnt_q == 4'h1);
endmodule
`default_nettype wire

// ==== bal_top_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bal_defs.svh"
// ==========
// Port-level timing and flag checks for the byte datapath.
module bal_top_checker (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                start,
  input wire logic [4:0]          op,
  input wire logic [1:0]          src,
  input wire logic                mem_rvalid,
  input wire logic [7:0]          acc,
  input wire bal_pkg::bal_flags_t flags,
  input wire logic [15:0]         pointer_pair,
  input wire logic                mem_rd,
  input wire logic [15:0]         mem_addr,
  input wire logic                done,
  input wire logic                busy
);
  import bal_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [4:0] op_q;   // Operation taken.
  logic [7:0] acc_q;  // Accumulator when taken.
  bal_flags_t fl_q;   // Flags when taken.
  wire logic  take = start && !busy;
  // Capture only at the taking edge, since the bench may move inputs later.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_q  <= 5'h00;
      acc_q <= 8'h00;
      fl_q  <= '0;
    end else if (take) begin
      op_q  <= op;
      acc_q <= acc;
      fl_q  <= flags;
    end
  end
  // The done pulse is sampled one edge after the last state, so a form of
  // N states shows N quiet samples and then done.
  a_take_sets_busy: assert property (
    take |=> busy) else $error("taken operation did not raise busy");
  a_reg_four_state: assert property (
    take && src == `BAL_SRC_REG && op inside {`BAL_OP_SUB, 5'h01, `BAL_OP_FIX, `BAL_OP_AND,
      `BAL_OP_XOR, `BAL_OP_OR, 5'h0a, 5'h0b, 5'h0c, 5'h0d} |=> !done [*4] ##1 done)
    else $error("register form did not finish in four states");
  a_imm_seven_state: assert property (
    take && src == `BAL_SRC_IMM && op inside {`BAL_OP_SUB, 5'h01, `BAL_OP_XOR, 5'h0a}
    |=> !done [*7] ##1 done) else $error("immediate form did not finish in seven states");
  a_five_state: assert property (
    take && src == `BAL_SRC_REG && op inside {`BAL_OP_INC, `BAL_OP_DEC, `BAL_OP_DECP}
    |=> !done [*5] ##1 done) else $error("single-step form did not finish in five states");
  a_pair_add_ten: assert property (
    take && op == `BAL_OP_PADD |-> ##11 done) else $error("pair add not ten states");
  a_mem_rd_holds: assert property (
    mem_rd && !mem_rvalid |=> mem_rd) else $error("memory read dropped before data");
  a_mem_addr_ptr: assert property (
    mem_rd |-> mem_addr == pointer_pair) else $error("memory address is not the pointer");
  a_cmp_keeps_acc: assert property (
    done && op_q == 5'h0a |-> acc == acc_q) else $error("compare changed the accumulator");
  a_rlc_result: assert property (
    done && op_q == 5'h0b |-> acc == {acc_q[6:0], acc_q[7]} && flags.carry_bit == acc_q[7]
      && flags[4:1] == fl_q[4:1]) else $error("left circular rotate wrong");
  a_rrc_result: assert property (
    done && op_q == 5'h0c |-> acc == {acc_q[0], acc_q[7:1]} && flags.carry_bit == acc_q[0]
      && flags[4:1] == fl_q[4:1]) else $error("right circular rotate wrong");
  a_ral_result: assert property (
    done && op_q == 5'h0d |-> acc == {acc_q[6:0], fl_q.carry_bit}
      && flags.carry_bit == acc_q[7]) else $error("rotate through carry wrong");
  a_incdec_carry: assert property (
    done && op_q inside {`BAL_OP_INC, `BAL_OP_DEC} |-> flags.carry_bit == fl_q.carry_bit)
    else $error("increment or decrement changed carry");
  a_pair_dec_flags: assert property (
    done && op_q == `BAL_OP_DECP |-> flags == fl_q) else $error("pair decrement moved flags");
  a_logic_carry: assert property (
    done && op_q inside {`BAL_OP_AND, `BAL_OP_XOR, `BAL_OP_OR} |-> !flags.carry_bit)
    else $error("logic operation left carry set");
  a_result_flags: assert property (
    done && op_q inside {`BAL_OP_SUB, 5'h01, `BAL_OP_XOR, `BAL_OP_OR} |-> flags.zero ==
      (acc == 8'h00) && flags.sign == acc[7] && flags.parity == ~^acc)
    else $error("zero sign or parity wrong");
endmodule
bind bal_top bal_top_checker u_bal_top_checker (.clk(clk), .nrst(nrst), .start(start),
  .op(op), .src(src), .mem_rvalid(mem_rvalid), .acc(acc), .flags(flags),
  .pointer_pair(pointer_pair), .mem_rd(mem_rd), .mem_addr(mem_addr), .done(done),
  .busy(busy));
`default_nettype wire

// ==== bal_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bal_defs.svh"
// ==========
// Bench: start each operation, time it to done and compare the results.
module bal_top_tb;
  import bal_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, start = 1'b0, acc_load = 1'b0, ptr_load = 1'b0;
  logic [4:0]  op = 5'h00;
  logic [1:0]  src = 2'h0;
  logic [7:0]  reg_operand = 8'h00, imm_byte = 8'h00, mem_rdata = 8'h00, acc_load_val = 8'h00;
  logic [15:0] pair_operand = 16'h0000, ptr_load_val = 16'h0000;
  logic        mem_rvalid = 1'b0, served = 1'b0;
  logic [7:0]  acc, reg_result, mem_wdata;
  bal_flags_t  flags;
  logic [15:0] pointer_pair, pair_result, mem_addr, side;
  logic        reg_wr, pair_wr, mem_wr, mem_rd, done, busy;
  int          err_total = 0, samples_checked = 0, mem_dly = 0, mcnt = 0;
  bal_top u_bal_top (.clk(clk), .nrst(nrst), .start(start), .op(op), .src(src),
    .reg_operand(reg_operand), .imm_byte(imm_byte), .pair_operand(pair_operand),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .acc_load(acc_load),
    .acc_load_val(acc_load_val), .ptr_load(ptr_load), .ptr_load_val(ptr_load_val),
    .acc(acc), .flags(flags), .pointer_pair(pointer_pair), .pair_result(pair_result),
    .reg_result(reg_result), .reg_wr(reg_wr), .pair_wr(pair_wr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .done(done), .busy(busy));
  always #5 clk = ~clk;
  // Memory answers once per operation after mem_dly cycles; busy low re-arms it.
  always @(negedge clk) begin
    mem_rvalid <= mem_rd && !served && mcnt >= mem_dly;
    served     <= busy && (served || (mem_rd && mcnt >= mem_dly));
    mcnt       <= mem_rd ? mcnt + 1 : 0;
  end
  function automatic logic [4:0] fl(input logic [7:0] r, input logic ac, input logic cy);
    return {r[7], r == 8'h00, ac, ~^r, cy};
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic want(input logic [7:0] a, input logic [4:0] f, input logic [4:0] m);
    chk("acc", {8'h00, a}, {8'h00, acc});
    chk("flags", {11'h000, f & m}, {11'h000, flags & m});
  endtask
  task automatic load(input logic [7:0] a, input logic [15:0] p);
    @(negedge clk);
    acc_load = 1'b1;
    acc_load_val = a;
    ptr_load = 1'b1;
    ptr_load_val = p;
    @(negedge clk);
    acc_load = 1'b0;
    ptr_load = 1'b0;
  endtask
  // One operation; n is the expected edge count to done, zero to skip timing.
  task automatic run(input logic [4:0] o, input logic [1:0] s, input logic [15:0] b,
                     input int n);
    int i;
    @(negedge clk);
    op = o;
    src = s;
    reg_operand = b[7:0];
    imm_byte = b[7:0];
    mem_rdata = b[7:0];
    pair_operand = b;
    start = 1'b1;
    side = 16'hxxxx;
    i = 0;
    @(negedge clk);
    start = 1'b0;
    while (done !== 1'b1 && i < 60) begin
      @(posedge clk);
      #1;
      i++;
      if (reg_wr === 1'b1) side = {8'h00, reg_result};
      if (mem_wr === 1'b1) side = {8'h00, mem_wdata};
      if (pair_wr === 1'b1) side = pair_result;
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("mismatch done expected 1 seen %b", done);
      end_of_test();
    end else if (n != 0) begin
      chk("states", n[15:0], i[15:0]);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    chk("acc_rst", 16'h0000, {8'h00, acc});
    chk("flags_rst", 16'h0000, {11'h000, flags});
    load(8'h10, 16'h0100);
    // The count is the number of edges from the taking edge to done: one per state.
    run(`BAL_OP_SUB, `BAL_SRC_REG, 16'h0001, 4);
    want(8'h0f, fl(8'h0f, 1'b1, 1'b0), 5'h1f);
    run(`BAL_OP_SUB, `BAL_SRC_IMM, 16'h0010, 7);
    want(8'hff, fl(8'hff, 1'b0, 1'b1), 5'h1f);
    run(5'h01, `BAL_SRC_IMM, 16'h000f, 7);
    want(8'hef, fl(8'hef, 1'b1, 1'b0), 5'h1f);
    run(5'h01, `BAL_SRC_REG, 16'h00ef, 4);
    want(8'h00, fl(8'h00, 1'b0, 1'b0), 5'h1f);
    run(`BAL_OP_SUB, `BAL_SRC_MEM, 16'h0080, 7);
    want(8'h80, fl(8'h80, 1'b0, 1'b1), 5'h1f);
    // A late memory answer: data at the seventh edge, retire two edges on.
    mem_dly = 6;
    run(5'h01, `BAL_SRC_MEM, 16'h007f, 9);
    want(8'h00, fl(8'h00, 1'b1, 1'b0), 5'h1f);
    mem_dly = 0;
    $display("subtract tests finished");
    run(`BAL_OP_INC, `BAL_SRC_REG, 16'h000f, 5);
    chk("inc", 16'h0010, side);
    want(8'h00, fl(8'h10, 1'b1, 1'b0), 5'h1f);
    run(`BAL_OP_DEC, `BAL_SRC_REG, 16'h0000, 5);
    chk("dec", 16'h00ff, side);
    want(8'h00, fl(8'hff, 1'b1, 1'b0), 5'h1f);
    run(`BAL_OP_INC, `BAL_SRC_MEM, 16'h00ff, 10);
    chk("inc_mem", 16'h0000, side);
    want(8'h00, fl(8'h00, 1'b1, 1'b0), 5'h1f);
    run(`BAL_OP_DECP, `BAL_SRC_REG, 16'h0000, 5);
    chk("pair_dec", 16'hffff, side);
    want(8'h00, fl(8'h00, 1'b1, 1'b0), 5'h1f);
    load(8'h00, 16'hffff);
    run(`BAL_OP_PADD, `BAL_SRC_REG, 16'h0002, 10);
    chk("pointer", 16'h0001, pointer_pair);
    want(8'h00, fl(8'h00, 1'b1, 1'b1), 5'h1f);
    $display("step and pair tests finished");
    load(8'h9b, 16'h0001);
    run(`BAL_OP_XOR, `BAL_SRC_IMM, 16'h0000, 7);
    want(8'h9b, fl(8'h9b, 1'b0, 1'b0), 5'h1f);
    run(`BAL_OP_FIX, `BAL_SRC_REG, 16'h0000, 4);
    want(8'h01, fl(8'h01, 1'b1, 1'b1), 5'h1f);
    run(`BAL_OP_FIX, `BAL_SRC_REG, 16'h0000, 4);
    want(8'h67, fl(8'h67, 1'b0, 1'b1), 5'h1f);
    load(8'hf0, 16'h0001);
    run(`BAL_OP_AND, `BAL_SRC_REG, 16'h003c, 4);
    want(8'h30, fl(8'h30, 1'b0, 1'b0), 5'h1b);
    run(`BAL_OP_OR, `BAL_SRC_MEM, 16'h0081, 7);
    want(8'hb1, fl(8'hb1, 1'b0, 1'b0), 5'h1f);
    run(5'h0a, `BAL_SRC_REG, 16'h00c0, 4);
    want(8'hb1, fl(8'hf1, 1'b0, 1'b1), 5'h1f);
    run(5'h0a, `BAL_SRC_IMM, 16'h00b1, 7);
    want(8'hb1, fl(8'h00, 1'b0, 1'b0), 5'h1f);
    $display("logic and compare tests finished");
    run(5'h0b, `BAL_SRC_REG, 16'h0000, 4);
    want(8'h63, fl(8'h00, 1'b0, 1'b1), 5'h1f);
    run(5'h0c, `BAL_SRC_REG, 16'h0000, 4);
    want(8'hb1, fl(8'h00, 1'b0, 1'b1), 5'h1f);
    load(8'h40, 16'h0001);
    run(5'h0d, `BAL_SRC_REG, 16'h0000, 4);
    want(8'h81, fl(8'h00, 1'b0, 1'b0), 5'h1f);
    $display("rotate tests finished");
    end_of_test();
  end
endmodule
`default_nettype wire
